// [pkg/meter_regs.svh]
// register offsets, command numbers, result codes and reset values of the command block
`ifndef METER_REGS_SVH
`define METER_REGS_SVH
`define FUNC_READ_HOLD   8'h03
`define FUNC_WRITE_MULTI 8'h10
`define CMD_BASE_ADDR    16'h012C
`define CMD_LAST_ADDR    16'h01A7
`define HANDLED_ADDR     16'h01A8
`define OUTCOME_ADDR     16'h01A9
`define CMD_WORDS        124
`define CHECK_WORDS      13
`define CMD_SET_CLOCK    16'h03E9
`define CMD_SET_COMM     16'h03EA
`define CMD_SET_POWER    16'h03EB
`define CMD_SET_HARM     16'h03EC
`define NP_SET_CLOCK     8'h06
`define NP_SET_COMM      8'h03
`define NP_SET_POWER     8'h0D
`define NP_SET_HARM      8'h03
`define RES_OK           16'h0000
`define RES_BAD_CMD      16'h0050
`define RES_BAD_PARAM    16'h0051
`define RES_BAD_COUNT    16'h0052
`define RES_NOT_DONE     16'h0053
`define YEAR_BASE        16'h07D0
`define MS_PER_SEC       16'h03E8
`define COIL_SEC_MAX     16'h014D
`define DEF_SLAVE_ADDR   8'h01
`define DEF_BAUD_CODE    3'h4
`define DEF_PARITY_CODE  2'h1
`endif

// [pkg/meter_pkg.sv]
// types shared by the meter command block
`include "meter_regs.svh"
package meter_pkg;
  typedef logic [`CHECK_WORDS-1:0][15:0] check_arr_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } word_wr_t;
  typedef struct packed {
    logic        done;
    logic [7:0]  func;
    logic [15:0] start;
    logic [7:0]  count;
  } frame_t;
  typedef struct packed {
    logic [7:0] slave_addr;
    logic [2:0] baud_code;
    logic [1:0] parity_code;
  } comm_cfg_t;
  typedef enum logic [2:0] {
    single_phase_line_neutral = 3'b000,
    single_phase_line_line    = 3'b001,
    three_phase_four_wire     = 3'b010,
    three_phase_three_wire    = 3'b011,
    split_phase_three_wire    = 3'b100
  } wiring_t;
  typedef struct packed {
    wiring_t     wiring;
    logic [15:0] nom_freq;
    logic [31:0] vt_primary;
    logic [15:0] vt_secondary;
    logic [31:0] coil_primary;
    logic [15:0] coil_secondary;
    logic [31:0] rcoil_primary;
    logic [15:0] rcoil_secondary;
    logic        volt_conn;
    logic        curr_conn;
  } power_cfg_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] word1;
    logic [15:0] word2;
    logic [15:0] word3;
    logic [15:0] word4;
  } clock_set_t;
  typedef struct packed {
    logic [7:0] hx;
    logic [7:0] hy;
    logic [7:0] hz;
  } harm_cfg_t;
endpackage

// [core/cmd_check.sv]
// parameter count and range checking of one command
`timescale 1ns/100ps
`include "meter_regs.svh"
module cmd_check
  import meter_pkg::*;
(
  input  wire logic [15:0] cmd,     // command number
  input  wire logic [7:0]  nparam,  // parameter words written
  input  wire check_arr_t  p,       // first parameter words
  output logic      [15:0] outcome  // result code
);
  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  wire ok_clock = in_rng(p[0], `YEAR_BASE, 16'h0833) && in_rng(p[1], 16'h0001, 16'h000C) &&
                  in_rng(p[2], 16'h0001, 16'h001F) && in_rng(p[3], 16'h0000, 16'h0017) &&
                  in_rng(p[4], 16'h0000, 16'h003B) && in_rng(p[5], 16'h0000, 16'h003B);
  wire ok_comm  = in_rng(p[0], 16'h0001, 16'h00F7) && in_rng(p[1], 16'h0000, 16'h0006) &&
                  in_rng(p[2], 16'h0000, 16'h0002);
  // two-word primaries shift the later slots: secondaries sit at 4, 7 and 10
  wire vt_ok    = (p[4] == 16'h0064) || (p[4] == 16'h006E) || (p[4] == 16'h0073) || (p[4] == 16'h0078);
  wire ok_power = in_rng(p[0], 16'h0000, 16'h0004) && ((p[1] == 16'h0032) || (p[1] == 16'h003C)) && vt_ok &&
                  in_rng(p[7], 16'h0000, `COIL_SEC_MAX) && in_rng(p[10], 16'h0000, `COIL_SEC_MAX) &&
                  in_rng(p[11], 16'h0000, 16'h0001) && in_rng(p[12], 16'h0000, 16'h0001);
  wire ok_harm  = in_rng(p[0], 16'h0002, 16'h0034) && in_rng(p[1], 16'h0002, 16'h0034) &&
                  in_rng(p[2], 16'h0002, 16'h0034);

  always_comb begin
    case (cmd)
      `CMD_SET_CLOCK: outcome = (nparam != `NP_SET_CLOCK) ? `RES_BAD_COUNT : (ok_clock ? `RES_OK : `RES_BAD_PARAM);
      `CMD_SET_COMM:  outcome = (nparam != `NP_SET_COMM)  ? `RES_BAD_COUNT : (ok_comm  ? `RES_OK : `RES_BAD_PARAM);
      `CMD_SET_POWER: outcome = (nparam != `NP_SET_POWER) ? `RES_BAD_COUNT : (ok_power ? `RES_OK : `RES_BAD_PARAM);
      `CMD_SET_HARM:  outcome = (nparam != `NP_SET_HARM)  ? `RES_BAD_COUNT : (ok_harm  ? `RES_OK : `RES_BAD_PARAM);
      default:        outcome = `RES_BAD_CMD;
    endcase
  end
endmodule

// [core/meter_cmd.sv]
// command register file and command interpreter of the power meter
`timescale 1ns/100ps
`include "meter_regs.svh"
module meter_cmd
  import meter_pkg::*;
(
  input  wire logic        clk,          // 10 MHz clock
  input  wire logic        rst_n,        // synchronous reset, active low
  input  wire word_wr_t    wr,           // one decoded function 16 register word
  input  wire frame_t      frame,        // end of a decoded write frame
  input  wire logic        rd_en,        // function 03 word read request
  input  wire logic [15:0] rd_addr,      // register address of the read
  input  wire logic        resp_sent,    // response to last write went out
  output logic      [15:0] rd_data,      // read word
  output logic             rd_valid,     // read word valid pulse
  output logic             rd_err,       // read of unmapped address pulse
  output logic             done,         // command finished pulse
  output clock_set_t       clock_set,    // clock load request
  output comm_cfg_t        comm_cfg,     // active link settings
  output power_cfg_t       power_cfg,    // power system settings
  output harm_cfg_t        harm_cfg      // harmonic orders
);
  logic [15:0] regs_q [`CMD_WORDS];
  logic [15:0] handled_q;
  logic [15:0] outcome_q;
  logic [15:0] rd_data_q;
  logic        rd_valid_q;
  logic        rd_err_q;
  logic        done_q;
  clock_set_t  clock_q;
  comm_cfg_t   comm_q;
  comm_cfg_t   comm_new_q;
  logic        comm_pend_q;
  power_cfg_t  power_q;
  harm_cfg_t   harm_q;
  check_arr_t  chk_p;
  logic [15:0] chk_out;

  function automatic logic [31:0] join32(input logic [15:0] hi, input logic [15:0] lo);
    join32 = {hi, lo};
  endfunction

  function automatic logic in_cmd(input logic [15:0] a);
    in_cmd = (a >= `CMD_BASE_ADDR) && (a <= `CMD_LAST_ADDR);
  endfunction

  wire [6:0]  wr_idx  = 7'(wr.addr - `CMD_BASE_ADDR);
  wire [6:0]  rd_idx  = 7'(rd_addr - `CMD_BASE_ADDR);
  // function 16 word writes land only in the command block
  wire        wr_hit  = wr.valid && in_cmd(wr.addr);
  // execution only from a function 16 frame starting at the command word
  wire        exec_w  = frame.done && (frame.func == `FUNC_WRITE_MULTI) &&
                        (frame.start == `CMD_BASE_ADDR) && (frame.count != 8'h00);
  wire [7:0]  nparam  = frame.count - 8'h01;
  wire [15:0] cmd_w   = regs_q[0];
  // a link settings change still waiting for its response blocks another link settings change
  wire        blocked = (cmd_w == `CMD_SET_COMM) && comm_pend_q && (chk_out == `RES_OK);
  wire [15:0] res_w   = blocked ? `RES_NOT_DONE : chk_out;
  wire        ok_w    = exec_w && (res_w == `RES_OK);
  wire        rd_cmd  = in_cmd(rd_addr);
  wire        rd_hnd  = rd_addr == `HANDLED_ADDR;
  wire        rd_out  = rd_addr == `OUTCOME_ADDR;
  wire        rd_bad  = !(rd_cmd || rd_hnd || rd_out);
  wire [15:0] rd_mux  = rd_cmd ? regs_q[rd_idx] : (rd_hnd ? handled_q : (rd_out ? outcome_q : 16'h0000));
  // year offset, bit 15 reserved zero
  wire [15:0] dt_w1   = {1'b0, 15'(regs_q[1] - `YEAR_BASE)};
  wire [15:0] dt_w2   = {regs_q[2][7:0], regs_q[3][7:0]};
  wire [15:0] dt_w3   = {regs_q[4][7:0], regs_q[5][7:0]};
  wire [15:0] dt_w4   = 16'(regs_q[6] * `MS_PER_SEC);

  // parameter words past the command's count are never looked at
  always_comb begin
    for (int i = 0; i < `CHECK_WORDS; i++) begin
      chk_p[i] = regs_q[i + 1];
    end
  end

  cmd_check u_check (
    .cmd     (cmd_w),
    .nparam  (nparam),
    .p       (chk_p),
    .outcome (chk_out)
  );

  always_ff @(posedge clk) begin
    if (wr_hit) begin
      regs_q[wr_idx] <= wr.data;
    end
  end

  // result registers follow each executed command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      handled_q <= 16'h0000;
      outcome_q <= `RES_OK;
      done_q    <= 1'b0;
    end else begin
      done_q <= exec_w;
      if (exec_w) begin
        handled_q <= cmd_w;
        outcome_q <= res_w;
      end
    end
  end

  // function 03 read, answered one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
      rd_err_q   <= 1'b0;
    end else begin
      rd_valid_q <= rd_en && !rd_bad;
      rd_err_q   <= rd_en && rd_bad;
      rd_data_q  <= rd_en ? rd_mux : rd_data_q;
    end
  end

  // clock load as the four-word date-time value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clock_q <= '0;
    end else begin
      clock_q.valid <= ok_w && (cmd_w == `CMD_SET_CLOCK);
      if (ok_w && (cmd_w == `CMD_SET_CLOCK)) begin
        clock_q.word1 <= dt_w1;
        clock_q.word2 <= dt_w2;
        clock_q.word3 <= dt_w3;
        clock_q.word4 <= dt_w4;
      end
    end
  end

  // settings held aside; applied once the acknowledgement left
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      comm_q      <= '{slave_addr: `DEF_SLAVE_ADDR, baud_code: `DEF_BAUD_CODE, parity_code: `DEF_PARITY_CODE};
      comm_new_q  <= '{slave_addr: `DEF_SLAVE_ADDR, baud_code: `DEF_BAUD_CODE, parity_code: `DEF_PARITY_CODE};
      comm_pend_q <= 1'b0;
    end else if (ok_w && (cmd_w == `CMD_SET_COMM)) begin
      comm_new_q  <= '{slave_addr: regs_q[1][7:0], baud_code: regs_q[2][2:0], parity_code: regs_q[3][1:0]};
      comm_pend_q <= 1'b1;
    end else if (comm_pend_q && resp_sent) begin
      comm_q      <= comm_new_q;
      comm_pend_q <= 1'b0;
    end
  end

  // power system words in order; values of two words use the same join
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_q <= '{wiring: three_phase_four_wire, nom_freq: 16'h0032, default: '0};
    end else if (ok_w && (cmd_w == `CMD_SET_POWER)) begin
      power_q.wiring          <= wiring_t'(regs_q[1][2:0]);
      power_q.nom_freq        <= regs_q[2];
      power_q.vt_primary      <= join32(regs_q[3], regs_q[4]);
      power_q.vt_secondary    <= regs_q[5];
      power_q.coil_primary    <= join32(regs_q[6], regs_q[7]);
      power_q.coil_secondary  <= regs_q[8];
      power_q.rcoil_primary   <= join32(regs_q[9], regs_q[10]);
      power_q.rcoil_secondary <= regs_q[11];
      power_q.volt_conn       <= regs_q[12][0];
      power_q.curr_conn       <= regs_q[13][0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      harm_q <= '{hx: 8'h02, hy: 8'h02, hz: 8'h02};
    end else if (ok_w && (cmd_w == `CMD_SET_HARM)) begin
      harm_q <= '{hx: regs_q[1][7:0], hy: regs_q[2][7:0], hz: regs_q[3][7:0]};
    end
  end

  assign rd_data   = rd_data_q;
  assign rd_valid  = rd_valid_q;
  assign rd_err    = rd_err_q;
  assign done      = done_q;
  assign clock_set = clock_q;
  assign comm_cfg  = comm_q;
  assign power_cfg = power_q;
  assign harm_cfg  = harm_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_exec_record: assert property (exec_w |=> done_q && handled_q == $past(cmd_w))
    else $error("handled command not recorded");
  chk_outcome_legal: assert property (done_q |-> outcome_q inside {`RES_OK, `RES_BAD_CMD, `RES_BAD_PARAM,
                                                            `RES_BAD_COUNT, `RES_NOT_DONE})
    else $error("illegal outcome code");
  chk_unknown_cmd: assert property (exec_w && !(cmd_w inside {`CMD_SET_CLOCK, `CMD_SET_COMM, `CMD_SET_POWER,
                                    `CMD_SET_HARM}) |=> outcome_q == `RES_BAD_CMD)
    else $error("unknown command not flagged");
  chk_clock_count: assert property (exec_w && cmd_w == `CMD_SET_CLOCK && nparam != `NP_SET_CLOCK
                                    |=> outcome_q == `RES_BAD_COUNT && !clock_q.valid)
    else $error("bad count on clock command");
  chk_comm_hold: assert property (comm_pend_q && !resp_sent |=> $stable(comm_q))
    else $error("link settings changed before response");
  chk_comm_apply: assert property (comm_pend_q && resp_sent && !exec_w |=> comm_q == $past(comm_new_q))
    else $error("link settings not applied");
  chk_read_outcome: assert property (rd_en && rd_out && !exec_w |=> rd_valid_q && rd_data_q == outcome_q)
    else $error("outcome read wrong");
  chk_read_unmapped: assert property (rd_en && rd_bad |=> rd_err_q && !rd_valid_q)
    else $error("unmapped read not refused");
  chk_date_word: assert property (clock_q.valid |-> clock_q.word1[15] == 1'b0
                                  && clock_q.word1[14:0] <= 15'h0063)
    else $error("date word one malformed");

  chk_comm_block: assert property (exec_w && blocked |=> outcome_q == `RES_NOT_DONE && $stable(comm_new_q))
    else $error("waiting link settings overwritten");

  cov_clock_ok: cover property (exec_w && cmd_w == `CMD_SET_CLOCK ##1 outcome_q == `RES_OK);
  cov_not_done: cover property (done_q && outcome_q == `RES_NOT_DONE);
  cov_comm_apply: cover property (ok_w && cmd_w == `CMD_SET_COMM ##[1:20] comm_pend_q && resp_sent);
  cov_bad_param: cover property (done_q && outcome_q == `RES_BAD_PARAM);
endmodule

// [dv/modbus_master_model.sv]
// behavioural master side: decoded write words, frame ends, word reads and response pulses
`timescale 1ns/100ps
`include "meter_regs.svh"
module modbus_master_model
  import meter_pkg::*;
(
  input  wire logic        clk,       // block clock
  output word_wr_t         wr,        // decoded register word
  output frame_t           frame,     // end of a write frame
  output logic             rd_en,     // word read request
  output logic      [15:0] rd_addr,   // read address
  output logic             resp_sent, // write response went out
  input  wire logic [15:0] rd_data,   // read word
  input  wire logic        rd_valid,  // read word valid
  input  wire logic        rd_err     // unmapped read
);
  initial begin
    wr        = '0;
    frame     = '0;
    rd_en     = 1'b0;
    rd_addr   = 16'h0000;
    resp_sent = 1'b0;
  end

  task automatic send_frame(input logic [15:0] w[$], input logic [15:0] start, input logic [7:0] func);
    for (int i = 0; i < w.size(); i++) begin
      @(posedge clk) #1;
      wr.valid = 1'b1;
      wr.addr  = start + 16'(i);
      wr.data  = w[i];
    end
    @(posedge clk) #1;
    // stale lines inverted so nothing can lean on old values
    wr.valid    = 1'b0;
    wr.addr     = ~wr.addr;
    wr.data     = ~wr.data;
    frame.done  = 1'b1;
    frame.func  = func;
    frame.start = start;
    frame.count = 8'(w.size());
    @(posedge clk) #1;
    frame.done  = 1'b0;
    frame.count = ~frame.count;
  endtask

  task automatic read_word(input logic [15:0] a, output logic [15:0] d, output logic v, output logic e);
    @(posedge clk) #1;
    rd_en   = 1'b1;
    rd_addr = a;
    @(posedge clk) #1;
    rd_en   = 1'b0;
    rd_addr = ~a;
    d       = rd_data;
    v       = rd_valid;
    e       = rd_err;
  endtask

  task automatic send_resp();
    @(posedge clk) #1;
    resp_sent = 1'b1;
    @(posedge clk) #1;
    resp_sent = 1'b0;
  endtask
endmodule

// [dv/meter_cmd_tb_top.sv]
// self-checking bench of the meter command block
`timescale 1ns/100ps
`include "meter_regs.svh"
module meter_cmd_tb_top import meter_pkg::*;;
  logic        clk;
  logic        rst_n;
  word_wr_t    wr;
  frame_t      frame;
  logic        rd_en;
  logic [15:0] rd_addr;
  logic        resp_sent;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        rd_err;
  logic        done;
  clock_set_t  clock_set;
  comm_cfg_t   comm_cfg;
  power_cfg_t  power_cfg;
  harm_cfg_t   harm_cfg;
  int          n_mismatch = 0;
  int          compares   = 0;

  meter_cmd meter_cmd_inst (.clk(clk), .rst_n(rst_n), .wr(wr), .frame(frame), .rd_en(rd_en),
    .rd_addr(rd_addr), .resp_sent(resp_sent), .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err),
    .done(done), .clock_set(clock_set), .comm_cfg(comm_cfg), .power_cfg(power_cfg), .harm_cfg(harm_cfg));
  modbus_master_model modbus_master_model_inst (.clk(clk), .wr(wr), .frame(frame), .rd_en(rd_en),
    .rd_addr(rd_addr), .resp_sent(resp_sent), .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [167:0] got, input logic [167:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    logic        e;
    modbus_master_model_inst.read_word(a, d, v, e);
    chk({v, e, d}, {2'b10, exp});
  endtask

  // done, clock load pulse only for a good 1001, then both result words
  task automatic run_cmd(input logic [15:0] w[$], input logic [15:0] res);
    modbus_master_model_inst.send_frame(w, `CMD_BASE_ADDR, `FUNC_WRITE_MULTI);
    chk(done, 1'b1);
    chk(clock_set.valid, w[0] == `CMD_SET_CLOCK && res == `RES_OK);
    rd_chk(`HANDLED_ADDR, w[0]);
    rd_chk(`OUTCOME_ADDR, res);
  endtask

  initial begin
    logic [15:0] d;
    logic        v;
    logic        e;
    logic [15:0] q[$];
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(comm_cfg, {`DEF_SLAVE_ADDR, `DEF_BAUD_CODE, `DEF_PARITY_CODE});
    chk(harm_cfg, 24'h020202);
    rd_chk(`HANDLED_ADDR, 16'h0000);
    rd_chk(`OUTCOME_ADDR, 16'h0000);
    modbus_master_model_inst.read_word(16'h01AA, d, v, e);
    chk({v, e, d}, {2'b01, 16'h0000});
    run_cmd('{`CMD_SET_CLOCK, 16'h07E0, 16'h0001, 16'h0001, 16'h000A, 16'h000A, 16'h000A}, `RES_OK);
    chk(clock_set[63:0], 64'h0010_0101_0A0A_2710);
    run_cmd('{`CMD_SET_CLOCK, 16'h0833, 16'h000C, 16'h001F, 16'h0017, 16'h003B, 16'h003B}, `RES_OK);
    chk(clock_set[63:0], 64'h0063_0C1F_173B_E678);
    run_cmd('{`CMD_SET_CLOCK, 16'h0834, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000}, `RES_BAD_PARAM);
    run_cmd('{`CMD_SET_CLOCK, 16'h07D0, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000}, `RES_BAD_PARAM);
    run_cmd('{`CMD_SET_CLOCK, 16'h07D0, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h003C}, `RES_BAD_PARAM);
    run_cmd('{`CMD_SET_CLOCK, 16'h07D0, 16'h0001, 16'h0001, 16'h0000, 16'h0000}, `RES_BAD_COUNT);
    run_cmd('{16'h03F2, 16'h0000}, `RES_BAD_CMD);
    chk(clock_set[63:0], 64'h0063_0C1F_173B_E678);
    run_cmd('{`CMD_SET_COMM, 16'h00F7, 16'h0006, 16'h0002}, `RES_OK);
    // old settings must survive until the acknowledgement is out
    chk(comm_cfg, {8'h01, 3'h4, 2'h1});
    run_cmd('{`CMD_SET_COMM, 16'h0005, 16'h0000, 16'h0000}, `RES_NOT_DONE);
    modbus_master_model_inst.send_resp();
    @(posedge clk) #1;
    chk(comm_cfg, {8'hF7, 3'h6, 2'h2});
    for (int b = 0; b < 7; b++) begin
      run_cmd('{`CMD_SET_COMM, 16'h0001, 16'(b), 16'(b % 3)}, `RES_OK);
      modbus_master_model_inst.send_resp();
      @(posedge clk) #1;
      chk(comm_cfg, {8'h01, 3'(b), 2'(b % 3)});
    end
    run_cmd('{`CMD_SET_COMM, 16'h0000, 16'h0000, 16'h0000}, `RES_BAD_PARAM);
    run_cmd('{`CMD_SET_COMM, 16'h00F8, 16'h0000, 16'h0000}, `RES_BAD_PARAM);
    run_cmd('{`CMD_SET_COMM, 16'h0001, 16'h0007, 16'h0000}, `RES_BAD_PARAM);
    run_cmd('{`CMD_SET_COMM, 16'h0001, 16'h0000, 16'h0003}, `RES_BAD_PARAM);
    q = '{`CMD_SET_POWER, 16'h0004, 16'h003C, 16'h0001, 16'h86A0, 16'h0078, 16'h0000, 16'h0064,
          16'h014D, 16'h0000, 16'h03E8, 16'h014D, 16'h0001, 16'h0001};
    run_cmd(q, `RES_OK);
    chk(power_cfg, power_cfg_t'{split_phase_three_wire, 16'h003C, 32'h000186A0, 16'h0078, 32'h00000064,
        16'h014D, 32'h000003E8, 16'h014D, 1'b1, 1'b1});
    q[8] = 16'h014E;
    run_cmd(q, `RES_BAD_PARAM);
    q[8] = 16'h014D;
    q[5] = 16'h0065;
    run_cmd(q, `RES_BAD_PARAM);
    // stale power words, one out of range, sit above the three orders
    run_cmd('{`CMD_SET_HARM, 16'h0002, 16'h0034, 16'h000A}, `RES_OK);
    chk(harm_cfg, 24'h02340A);
    run_cmd('{`CMD_SET_HARM, 16'h0002, 16'h0035, 16'h000A}, `RES_BAD_PARAM);
    modbus_master_model_inst.send_frame('{16'h03F2}, `CMD_BASE_ADDR, `FUNC_READ_HOLD);
    chk(done, 1'b0);
    modbus_master_model_inst.send_frame('{16'h1234}, `HANDLED_ADDR, `FUNC_WRITE_MULTI);
    chk(done, 1'b0);
    rd_chk(`CMD_BASE_ADDR, 16'h03F2);
    rd_chk(`HANDLED_ADDR, `CMD_SET_HARM);
    rd_chk(`OUTCOME_ADDR, `RES_BAD_PARAM);
    wrap_up();
  end

  // run needs well under two thousand cycles
  initial begin
    #(100 * 5000);
    n_mismatch++;
    wrap_up();
  end
endmodule
